// ---- logic/sms_station.sv ----
/*
  Setpoint source selection and manual control station with an AXI4-Lite
  register port. Assumes keys and digital inputs synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sms_defs.svh"
// What this block does
// R1 - shift key steps display levels I to IV
// R2 - x/w lamps lit or flashing per level
// R3 - internal key and enable pick active setpoint
// R4 - enable switching static, no acknowledgement
// R5 - external setpoint from analog or serial source
// R6 - track inactive setpoints only when option zero
// R7 - analog source instrument tracks itself
// R8 - hold flag only when no analog feedback
// R9 - inverted status blocks internal setpoint adjust
// R10 - wired-or zero disables delta-w keys
// R11 - source switch starts from previous value
// R12 - manual station replaces automatic with hold
// R13 - hold keeps last value, ignores delta-y keys
// R14 - outside party drives tracking command, value
// R15 - manual lock two forces permanent manual
// R16 - structures two, three: internal, external feedback
// R17 - priority option picks manual or tracking
// R18 - inputs sampled synchronously, evaluated every cycle
module sms_station #(
  parameter int unsigned VW = 16,
  parameter int unsigned FLASH_CYCLES = `SMS_CLK_HZ / 1000 * `SMS_FLASH_HALF_MS
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // axi4-lite slave
  input wire logic [`SMS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SMS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // front keys
  input wire logic shift_key,
  input wire logic internal_key,
  input wire logic dw_up_key,
  input wire logic dw_down_key,
  input wire logic manual_key,
  input wire logic dy_up_key,
  input wire logic dy_down_key,
  // digital and analog inputs
  input wire logic computer_enable,
  input wire logic manual_input,
  input wire logic tracking_command,
  input wire logic [3:0][VW-1:0] analog_in,
  input wire logic [VW-1:0] tracking_value_input,
  input wire logic [VW-1:0] external_feedback,
  // status and values
  output logic internal_status_out,
  output logic continuous_setpoint_status_n,
  output logic setpoint_hold_flag,
  output logic [VW-1:0] active_setpoint,
  output logic [VW-1:0] manipulated_variable,
  output logic step_up,
  output logic step_down,
  output logic manual_lamp,
  output logic y_ext_lamp,
  // display
  output logic [1:0] display_level,
  output logic x_lamp,
  output logic w_lamp
);

  if (VW < 2 || VW > 32) begin : g_chk
    $error("sms_station: VW must lie in 2..32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      old[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
    merge = old;
  endfunction : merge

  function automatic logic [VW-1:0] step(input logic [VW-1:0] v, input logic up, input logic dn);
    step = v;
    if (up && !dn && v != {VW{1'b1}}) begin
      step = v + VW'(1);
    end else if (dn && !up && v != '0) begin
      step = v - VW'(1);
    end
  endfunction : step

  // analog on 0,1,4,5 and the spare codes; serial on 2,3
  function automatic logic is_serial(input logic [2:0] opt);
    is_serial = (opt == 3'h2) || (opt == 3'h3);
  endfunction : is_serial

  ////////////////////////////////////////////////////////////////////////////
  // register port

  sms_pkg::sms_cfg_t cfg_q, cfg_d;
  logic [VW-1:0] ser_q, ser_d;
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [`SMS_ADDR_W-1:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic [31:0] status_word;
  logic do_wr;

  sms_pkg::sms_src_t src_q, src_d;
  sms_pkg::sms_ymode_t ym_q, ym_d;
  logic [VW-1:0] wi_q, wi_d, act_q, act_d, y_q, y_d, ext_val;
  logic rb_q, rb_d, rcn_q, rcn_d, sh_q, sh_d, sup_q, sup_d, sdn_q, sdn_d;
  logic mreq_q, mreq_d, mkey_q, dwu_q, dwd_q, dyu_q, dyd_q;
  logic int_or_ce, man_act, trk_req, ser_track;

  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    cfg_d = cfg_q;
    do_wr = 1'b0;
    if (s_axi_awvalid && !aw_q && !bv_q) begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q && !bv_q) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (aw_q && w_q) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = `SMS_RESP_OKAY;
      if (awa_q == `SMS_CFG_OFF) begin
        cfg_d = sms_pkg::sms_cfg_t'(merge(cfg_q, wd_q, ws_q));
        cfg_d.rsvd = '0;
      end else if (awa_q == `SMS_SERIAL_SP_OFF) begin
        do_wr = 1'b1;
      end else if (awa_q != `SMS_STATUS_OFF && awa_q != `SMS_ACTIVE_SP_OFF && awa_q != `SMS_MANIP_OFF) begin
        br_d = `SMS_RESP_SLVERR;
      end
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end else if (s_axi_arvalid && !rv_q) begin
      rv_d = 1'b1;
      rr_d = `SMS_RESP_OKAY;
      if (s_axi_araddr == `SMS_CFG_OFF) begin
        rd_d = cfg_q;
      end else if (s_axi_araddr == `SMS_SERIAL_SP_OFF) begin
        rd_d = 32'(ser_q);
      end else if (s_axi_araddr == `SMS_STATUS_OFF) begin
        rd_d = status_word;
      end else if (s_axi_araddr == `SMS_ACTIVE_SP_OFF) begin
        rd_d = 32'(act_q);
      end else if (s_axi_araddr == `SMS_MANIP_OFF) begin
        rd_d = 32'(y_q);
      end else begin
        rd_d = `SMS_ZERO32;
        rr_d = `SMS_RESP_SLVERR;
      end
    end
  end

  assign status_word = {21'h0, w_lamp, x_lamp, display_level, rcn_q, rb_q, sh_q, 2'(ym_q), 2'(src_q)};

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= '0;
      wd_q <= `SMS_ZERO32;
      ws_q <= 4'h0;
      bv_q <= 1'b0;
      br_q <= `SMS_RESP_OKAY;
      rv_q <= 1'b0;
      rd_q <= `SMS_ZERO32;
      rr_q <= `SMS_RESP_OKAY;
      cfg_q <= sms_pkg::sms_cfg_t'(`SMS_CFG_RST);
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bv_q <= bv_d;
      br_q <= br_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
      cfg_q <= cfg_d;
    end
  end

  // ready is held low once the half is captured, so no second beat slips in
  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready = !w_q && !bv_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;

  ////////////////////////////////////////////////////////////////////////////
  // setpoint selection

  always_comb begin
    int_or_ce = rb_q | computer_enable; // [R10]
    ser_track = is_serial(cfg_q.external_source_option);
    // [R5]
    ext_val = ser_track ? ser_q : analog_in[cfg_q.analog_setpoint_input_assign];
    // static enable level, no acknowledge handshake [R4] [R18]
    if (!internal_key) begin
      src_d = sms_pkg::SMS_SRC_EXT; // [R3]
    end else if (!computer_enable) begin
      src_d = sms_pkg::SMS_SRC_INT;
    end else if (cfg_q.hold_setpoint_select) begin
      src_d = sms_pkg::SMS_SRC_HOLD; // [R8]
    end else begin
      src_d = sms_pkg::SMS_SRC_EXT;
    end
    rb_d = internal_key;
    rcn_d = (src_d != sms_pkg::SMS_SRC_INT);
    sh_d = (src_d == sms_pkg::SMS_SRC_HOLD);
    wi_d = wi_q;
    ser_d = do_wr ? wd_q[VW-1:0] : ser_q;
    if (src_q == sms_pkg::SMS_SRC_INT && !rcn_q && int_or_ce) begin
      wi_d = step(wi_q, dw_up_key && !dwu_q, dw_down_key && !dwd_q); // [R9] [R10]
    end
    if (src_d != src_q) begin
      // newly active internal or serial source starts at the old value [R11]
      if (src_d == sms_pkg::SMS_SRC_INT) begin
        wi_d = act_q;
      end else if (src_d == sms_pkg::SMS_SRC_EXT && ser_track && !do_wr) begin
        ser_d = act_q;
      end
      act_d = act_q;
    end else begin
      if (!cfg_q.tracking_option) begin
        // analog source is left to its own instrument [R6] [R7]
        if (src_q != sms_pkg::SMS_SRC_INT) begin
          wi_d = act_q;
        end else if (ser_track && !do_wr) begin
          ser_d = act_q;
        end
      end
      case (src_q)
        sms_pkg::SMS_SRC_INT: act_d = wi_q;
        sms_pkg::SMS_SRC_EXT: act_d = ext_val;
        default: act_d = act_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // manual control station

  always_comb begin
    mreq_d = mreq_q ^ (manual_key && !mkey_q);
    man_act = mreq_q || manual_input;
    // no tracking with internal feedback: the held value stays
    trk_req = tracking_command && cfg_q.output_structure_option != `SMS_STRUCT_S_INTERNAL; // [R14] [R16]
    if (cfg_q.manual_lock_option == `SMS_MANUAL_LOCK_FIXED) begin
      ym_d = sms_pkg::SMS_Y_MANUAL; // [R15]
    end else if (man_act && trk_req) begin
      ym_d = cfg_q.priority_option ? sms_pkg::SMS_Y_MANUAL : sms_pkg::SMS_Y_TRACK; // [R17]
    end else if (man_act) begin
      ym_d = sms_pkg::SMS_Y_MANUAL;
    end else if (trk_req) begin
      ym_d = sms_pkg::SMS_Y_TRACK;
    end else begin
      ym_d = sms_pkg::SMS_Y_HOLD; // [R12]
    end
    sup_d = 1'b0;
    sdn_d = 1'b0;
    case (ym_q)
      sms_pkg::SMS_Y_MANUAL: begin
        y_d = step(y_q, dy_up_key && !dyu_q, dy_down_key && !dyd_q);
        if (cfg_q.output_structure_option != 2'h0) begin
          sup_d = dy_up_key && !dy_down_key;
          sdn_d = dy_down_key && !dy_up_key;
        end
      end
      sms_pkg::SMS_Y_TRACK: y_d = tracking_value_input;
      default: y_d = y_q; // [R13]
    endcase
    if (cfg_q.output_structure_option == `SMS_STRUCT_S_EXTERNAL && ym_q != sms_pkg::SMS_Y_TRACK) begin
      y_d = external_feedback; // [R16]
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      src_q <= sms_pkg::SMS_SRC_EXT;
      ym_q <= sms_pkg::SMS_Y_HOLD;
      wi_q <= '0;
      ser_q <= '0;
      act_q <= '0;
      y_q <= '0;
      rb_q <= 1'b0;
      rcn_q <= 1'b1;
      sh_q <= 1'b0;
      sup_q <= 1'b0;
      sdn_q <= 1'b0;
      mreq_q <= 1'b0;
      mkey_q <= 1'b0;
      dwu_q <= 1'b0;
      dwd_q <= 1'b0;
      dyu_q <= 1'b0;
      dyd_q <= 1'b0;
    end else begin
      src_q <= src_d;
      ym_q <= ym_d;
      wi_q <= wi_d;
      ser_q <= ser_d;
      act_q <= act_d;
      y_q <= y_d;
      rb_q <= rb_d;
      rcn_q <= rcn_d;
      sh_q <= sh_d;
      sup_q <= sup_d;
      sdn_q <= sdn_d;
      mreq_q <= mreq_d;
      mkey_q <= manual_key;
      dwu_q <= dw_up_key;
      dwd_q <= dw_down_key;
      dyu_q <= dy_up_key;
      dyd_q <= dy_down_key;
    end
  end

  assign internal_status_out = rb_q;
  assign continuous_setpoint_status_n = rcn_q;
  assign setpoint_hold_flag = sh_q;
  assign active_setpoint = act_q;
  assign manipulated_variable = y_q;
  assign step_up = sup_q;
  assign step_down = sdn_q;
  assign manual_lamp = (ym_q == sms_pkg::SMS_Y_MANUAL);
  assign y_ext_lamp = (ym_q == sms_pkg::SMS_Y_TRACK);

  sms_display #(.FLASH_CYCLES(FLASH_CYCLES)) u_display (
    .clock(clock),
    .reset(reset),
    .shift_key(shift_key),
    .display_order_select(cfg_q.display_order_select),
    .display_level(display_level),
    .x_lamp(x_lamp),
    .w_lamp(w_lamp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_SRC_EXT: assert property (@(posedge clock) disable iff (reset)
    !internal_key |=> src_q == sms_pkg::SMS_SRC_EXT && !rb_q) else $error("external setpoint not active"); // [R3]
  AST_SRC_INT: assert property (@(posedge clock) disable iff (reset)
    internal_key && !computer_enable |=> src_q == sms_pkg::SMS_SRC_INT && !rcn_q) else $error("internal not active"); // [R3]
  AST_SRC_HOLD: assert property (@(posedge clock) disable iff (reset)
    internal_key && computer_enable && cfg_q.hold_setpoint_select |=> setpoint_hold_flag)
    else $error("hold flag not set"); // [R3]
  AST_BUMPLESS: assert property (@(posedge clock) disable iff (reset)
    src_d != src_q |=> act_q == $past(act_q) ##1 (src_q != sms_pkg::SMS_SRC_INT || wi_q == $past(act_q, 2)))
    else $error("source switch not bumpless"); // [R11]
  AST_DW_BLOCKED: assert property (@(posedge clock) disable iff (reset)
    (!int_or_ce || rcn_q) && cfg_q.tracking_option && src_d == src_q |=> wi_q == $past(wi_q))
    else $error("internal setpoint moved while blocked"); // [R9]
  AST_NO_TRACK: assert property (@(posedge clock) disable iff (reset)
    cfg_q.tracking_option && src_q == sms_pkg::SMS_SRC_INT && src_d == src_q && !do_wr |=> $stable(ser_q))
    else $error("serial setpoint tracked with tracking off"); // [R6]
  AST_LOCK: assert property (@(posedge clock) disable iff (reset)
    cfg_q.manual_lock_option == `SMS_MANUAL_LOCK_FIXED |=> manual_lamp) else $error("manual lock left manual"); // [R15]
  AST_PRIO: assert property (@(posedge clock) disable iff (reset)
    man_act && trk_req && cfg_q.manual_lock_option != `SMS_MANUAL_LOCK_FIXED
      |=> (ym_q == sms_pkg::SMS_Y_MANUAL) == $past(cfg_q.priority_option)) else $error("wrong priority"); // [R17]
  AST_HOLD_KEEP: assert property (@(posedge clock) disable iff (reset)
    ym_q == sms_pkg::SMS_Y_HOLD && cfg_q.output_structure_option != `SMS_STRUCT_S_EXTERNAL
      |=> y_q == $past(y_q)) else $error("held value changed"); // [R13]
  AST_TRACK_VAL: assert property (@(posedge clock) disable iff (reset)
    ym_q == sms_pkg::SMS_Y_TRACK |=> y_q == $past(tracking_value_input)) else $error("tracking value not taken"); // [R14]
  AST_B_STABLE: assert property (@(posedge clock) disable iff (reset)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");

  COV_SWITCH_INT: cover property (@(posedge clock) disable iff (reset)
    src_q == sms_pkg::SMS_SRC_EXT ##1 src_q == sms_pkg::SMS_SRC_INT);
  COV_TRACK: cover property (@(posedge clock) disable iff (reset) ym_q == sms_pkg::SMS_Y_TRACK);
  COV_WRITE: cover property (@(posedge clock) disable iff (reset) s_axi_bvalid && s_axi_bready);

endmodule : sms_station
`default_nettype wire

// ---- logic/sms_defs.svh ----
/*
  Offsets, reset values and timing figures of the setpoint and manual
  station selector. Assumes inclusion by bare name in every file that needs them.
*/
`ifndef SMS_DEFS_SVH
`define SMS_DEFS_SVH

// register byte offsets
`define SMS_CFG_OFF 8'h00
`define SMS_SERIAL_SP_OFF 8'h04
`define SMS_STATUS_OFF 8'h08
`define SMS_ACTIVE_SP_OFF 8'h0c
`define SMS_MANIP_OFF 8'h10
`define SMS_ADDR_W 8

// reset values
`define SMS_CFG_RST 32'h0000_0000
`define SMS_ZERO32 32'h0000_0000

// axi responses
`define SMS_RESP_OKAY 2'h0
`define SMS_RESP_SLVERR 2'h2

// option codes
`define SMS_MANUAL_LOCK_FIXED 3'h2
`define SMS_STRUCT_S_INTERNAL 2'h2
`define SMS_STRUCT_S_EXTERNAL 2'h3
`define SMS_ORDER_NO_X_FLASH 3'h6

// display levels I to IV
`define SMS_LVL_I 2'h0
`define SMS_LVL_II 2'h1
`define SMS_LVL_III 2'h2
`define SMS_LVL_IV 2'h3

// flash timing: 1:1 rhythm, half period in ms
`define SMS_CLK_HZ 50000000
`define SMS_FLASH_HALF_MS 500

`endif

// ---- logic/sms_pkg.sv ----
/*
  Types of the setpoint and manual station selector.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package sms_pkg;

  typedef enum logic [1:0] {SMS_SRC_EXT, SMS_SRC_INT, SMS_SRC_HOLD} sms_src_t;

  typedef enum logic [1:0] {SMS_Y_HOLD, SMS_Y_MANUAL, SMS_Y_TRACK} sms_ymode_t;

  // configuration word, low bits first from the bottom of the struct
  typedef struct packed {
    logic [14:0] rsvd;
    logic [1:0] analog_setpoint_input_assign;
    logic [1:0] output_structure_option;
    logic [2:0] manual_lock_option;
    logic priority_option;
    logic acknowledge_option;
    logic tracking_option;
    logic hold_setpoint_select;
    logic [2:0] external_source_option;
    logic [2:0] display_order_select;
  } sms_cfg_t;

endpackage : sms_pkg
`default_nettype wire

// ---- logic/sms_display.sv ----
/*
  Display level stepping and x/w lamp drive.
  Assumes a synchronous shift key level and a free-running clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sms_defs.svh"
module sms_display #(
  parameter int unsigned FLASH_CYCLES = 25000000
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // controls
  input wire logic shift_key,
  input wire logic [2:0] display_order_select,
  // indication
  output logic [1:0] display_level,
  output logic x_lamp,
  output logic w_lamp
);

  if (FLASH_CYCLES < 2) begin : g_chk
    $error("sms_display: FLASH_CYCLES must be at least 2");
  end

  // levels offered per display order, bit i is level i
  function automatic logic [3:0] offered(input logic [2:0] sel);
    case (sel)
      3'h0: offered = 4'h3;
      3'h1: offered = 4'h7;
      3'h2: offered = 4'hb;
      3'h4: offered = 4'h1;
      3'h5: offered = 4'h2;
      3'h6: offered = 4'h4;
      default: offered = 4'hf;
    endcase
  endfunction : offered

  function automatic logic [1:0] next_level(input logic [1:0] lvl, input logic [3:0] mask);
    logic [1:0] cand;
    logic found;
    next_level = lvl;
    found = 1'b0;
    for (int i = 1; i <= 4; i++) begin
      cand = lvl + 2'(i);
      if (!found && mask[cand]) begin
        next_level = cand;
        found = 1'b1;
      end
    end
  endfunction : next_level

  logic [1:0] lvl_q, lvl_d;
  logic shift_q;
  logic [31:0] cnt_q, cnt_d;
  logic phase_q, phase_d;
  logic x_d, w_d;
  logic [3:0] mask;

  always_comb begin
    mask = offered(display_order_select);
    lvl_d = lvl_q;
    if (!mask[lvl_q]) begin
      lvl_d = next_level(lvl_q, mask);
    end else if (shift_key && !shift_q) begin
      lvl_d = next_level(lvl_q, mask); // [R1]
    end
    cnt_d = cnt_q + 32'h1;
    phase_d = phase_q;
    if (cnt_q >= 32'(FLASH_CYCLES - 1)) begin
      cnt_d = 32'h0;
      phase_d = !phase_q;
    end
    // [R2]
    x_d = (lvl_q == `SMS_LVL_I) ||
          (lvl_q == `SMS_LVL_III && phase_q && display_order_select != `SMS_ORDER_NO_X_FLASH);
    w_d = (lvl_q == `SMS_LVL_II) || (lvl_q == `SMS_LVL_IV && phase_q);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lvl_q <= `SMS_LVL_I;
      shift_q <= 1'b0;
      cnt_q <= 32'h0;
      phase_q <= 1'b0;
      x_lamp <= 1'b0;
      w_lamp <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      shift_q <= shift_key;
      cnt_q <= cnt_d;
      phase_q <= phase_d;
      x_lamp <= x_d;
      w_lamp <= w_d;
    end
  end

  assign display_level = lvl_q;

  AST_XLAMP_LEVEL_I: assert property (@(posedge clock) disable iff (reset)
    lvl_q == `SMS_LVL_I |=> x_lamp && !w_lamp) else $error("x lamp not lit at level I"); // [R2]
  AST_SHIFT_ADVANCE: assert property (@(posedge clock) disable iff (reset)
    shift_key && !shift_q && mask[lvl_q] && $stable(display_order_select) && mask != 4'h1 && mask != 4'h2
      && mask != 4'h4 |=> lvl_q != $past(lvl_q)) else $error("shift press did not advance level"); // [R1]
  COV_LEVEL_IV: cover property (@(posedge clock) disable iff (reset) lvl_q == `SMS_LVL_IV && w_lamp);

endmodule : sms_display
`default_nettype wire

// ---- tb/sms_partner_model.sv ----
/*
  Outside party of the manual station: raises the tracking command and
  supplies the tracking value. Assumes the bench asks via track_req.
*/
`timescale 1ns/1ps
`default_nettype none
module sms_partner_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // request from bench
  input wire logic track_req,
  input wire logic [15:0] track_val,
  // to the station
  output logic tracking_command,
  output logic [15:0] tracking_value_input
);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tracking_command <= 1'b0;
      tracking_value_input <= 16'h0000;
    end else begin
      tracking_command <= track_req;
      // idle word keeps flipping so a stale value is never trusted
      tracking_value_input <= track_req ? track_val : ~tracking_value_input;
    end
  end
endmodule : sms_partner_model
`default_nettype wire

// ---- tb/sms_station_bench.sv ----
/*
  Bench for the station: AXI4-Lite tasks, key presses, port checks.
  Assumes the partner model drives tracking inputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sms_defs.svh"
module sms_station_bench;
  localparam logic [1:0] OK = `SMS_RESP_OKAY;
  localparam logic [1:0] ER = `SMS_RESP_SLVERR;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [`SMS_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, display_level;
  logic [5:0] keys = '0;
  logic internal_key = 0, computer_enable = 0, manual_input = 0, track_req = 0, tracking_command;
  logic [3:0][15:0] analog_in = 64'h0000_0000_0077_0000;
  logic [15:0] tracking_value_input, external_feedback = '0, active_setpoint, manipulated_variable;
  logic internal_status_out, continuous_setpoint_status_n, setpoint_hold_flag, step_up, step_down;
  logic manual_lamp, y_ext_lamp, x_lamp, w_lamp;
  int error_cnt = 0;
  int checks_done = 0;
  always #10 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  sms_partner_model i_partner (.clock, .reset, .track_req, .track_val(16'h1234), .tracking_command,
    .tracking_value_input);
  sms_station #(.VW(16), .FLASH_CYCLES(4)) i_dut (.clock, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .shift_key(keys[2]), .internal_key,
    .dw_up_key(keys[0]), .dw_down_key(keys[3]), .manual_key(keys[5]), .dy_up_key(keys[1]),
    .dy_down_key(keys[4]), .computer_enable, .manual_input, .tracking_command, .analog_in,
    .tracking_value_input, .external_feedback, .internal_status_out, .continuous_setpoint_status_n,
    .setpoint_hold_flag, .active_setpoint, .manipulated_variable, .step_up, .step_down, .manual_lamp,
    .y_ext_lamp, .display_level, .x_lamp, .w_lamp);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic st(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : st
  task automatic press(input int k);
    @(posedge clock);
    keys <= 6'(1 << k);
    @(posedge clock);
    keys <= 6'h0;
    st(2);
  endtask : press
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
    st(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", exp, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask : rd
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    int n;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rd(`SMS_CFG_OFF, `SMS_CFG_RST, OK);
    rd(`SMS_STATUS_OFF, 32'h240, OK);
    rd(8'h14, `SMS_ZERO32, ER);
    wr(8'h14, 32'hffff_ffff, ER);
    $display("test registers done");
    wr(`SMS_CFG_OFF, 32'h10, OK);
    press(0);
    chk("active_setpoint", 0, 32'(active_setpoint));
    @(posedge clock);
    internal_key <= 1'b1;
    st(3);
    chk("cont_n", 0, 32'(continuous_setpoint_status_n));
    chk("internal_status_out", 1, 32'(internal_status_out));
    press(0);
    press(0);
    chk("active_setpoint", 2, 32'(active_setpoint));
    @(posedge clock);
    computer_enable <= 1'b1;
    st(3);
    chk("active_setpoint", 2, 32'(active_setpoint));
    rd(`SMS_SERIAL_SP_OFF, 32'h2, OK);
    wr(`SMS_CFG_OFF, 32'h50, OK);
    st(2);
    chk("setpoint_hold_flag", 1, 32'(setpoint_hold_flag));
    @(posedge clock);
    computer_enable <= 1'b0;
    internal_key <= 1'b0;
    wr(`SMS_CFG_OFF, 32'h90, OK);
    wr(`SMS_SERIAL_SP_OFF, 32'h5, OK);
    chk("active_setpoint", 5, 32'(active_setpoint));
    @(posedge clock);
    internal_key <= 1'b1;
    st(3);
    press(0);
    chk("active_setpoint", 6, 32'(active_setpoint));
    rd(`SMS_SERIAL_SP_OFF, 32'h5, OK);
    @(posedge clock);
    internal_key <= 1'b0;
    st(3);
    chk("active_setpoint", 6, 32'(active_setpoint));
    wr(`SMS_CFG_OFF, 32'h8000, OK);
    chk("active_setpoint", 32'h77, 32'(active_setpoint));
    $display("test setpoint done");
    wr(`SMS_CFG_OFF, 32'h800, OK);
    st(2);
    chk("manual_lamp", 1, 32'(manual_lamp));
    press(1);
    chk("manipulated_variable", 1, 32'(manipulated_variable));
    wr(`SMS_CFG_OFF, 32'h0, OK);
    st(2);
    press(1);
    chk("manipulated_variable", 1, 32'(manipulated_variable));
    press(5);
    chk("manual_lamp", 1, 32'(manual_lamp));
    press(5);
    chk("manual_lamp", 0, 32'(manual_lamp));
    @(posedge clock);
    manual_input <= 1'b1;
    track_req <= 1'b1;
    st(4);
    chk("y_ext_lamp", 1, 32'(y_ext_lamp));
    chk("manipulated_variable", 32'h1234, 32'(manipulated_variable));
    wr(`SMS_CFG_OFF, 32'h200, OK);
    st(2);
    chk("manual_lamp", 1, 32'(manual_lamp));
    chk("y_ext_lamp", 0, 32'(y_ext_lamp));
    wr(`SMS_CFG_OFF, 32'h4000, OK);
    st(2);
    chk("y_ext_lamp", 0, 32'(y_ext_lamp));
    @(posedge clock);
    keys <= 6'h2;
    st(1);
    chk("step_up", 1, 32'(step_up));
    chk("step_down", 0, 32'(step_down));
    @(posedge clock);
    keys <= 6'h0;
    track_req <= 1'b0;
    manual_input <= 1'b0;
    external_feedback <= 16'h0042;
    wr(`SMS_CFG_OFF, 32'h6000, OK);
    st(3);
    chk("manipulated_variable", 32'h42, 32'(manipulated_variable));
    $display("test manual station done");
    wr(`SMS_CFG_OFF, 32'h0, OK);
    press(2);
    chk("display_level", 1, 32'(display_level));
    chk("w_lamp", 1, 32'(w_lamp));
    press(2);
    chk("display_level", 0, 32'(display_level));
    wr(`SMS_CFG_OFF, 32'h3, OK);
    press(2);
    press(2);
    chk("display_level", 2, 32'(display_level));
    n = 0;
    repeat (8) begin
      @(negedge clock);
      n += int'(x_lamp);
    end
    chk("x_lamp_on_cycles", 4, n);
    $display("test display done");
    print_verdict();
  end
endmodule : sms_station_bench
`default_nettype wire
